/* File: logic/tmr_pkg.sv */
// Package with the register map, field positions and modes of the timer.
package tmr_pkg;
   localparam int TMR_AW = 8;
   localparam int TMR_DW = 32;
   localparam logic [7:0] TMR_CTRL_OFS = 8'h00;
   localparam logic [7:0] TMR_PERIOD_OFS = 8'h04;
   localparam logic [7:0] TMR_COUNT_OFS = 8'h08;
   localparam logic [7:0] TMR_STATUS_OFS = 8'h0C;
   localparam logic [7:0] TMR_IRQCFG_OFS = 8'h10;
   localparam int TMR_ON_BIT = 15;
   localparam int TMR_IDLE_HALT_BIT = 13;
   localparam int TMR_GATED_BIT = 6;
   localparam int TMR_PRESCALE_LSB = 4;
   localparam int TMR_RESYNC_BIT = 2;
   localparam int TMR_CLKSRC_BIT = 1;
   localparam int TMR_FLAG_BIT = 0;
   localparam int TMR_IRQ_EN_BIT = 0;
   localparam int TMR_IRQ_PRIO_LSB = 1;
   localparam logic [15:0] TMR_CTRL_MASK = 16'hA076;
   localparam logic [15:0] TMR_CTRL_RST = 16'h0000;
   localparam logic [15:0] TMR_PERIOD_RST = 16'hFFFF;
   localparam logic [15:0] TMR_COUNT_RST = 16'h0000;
   localparam logic [3:0] TMR_IRQCFG_RST = 4'h0;
   localparam logic [7:0] TMR_PRE_RST = 8'h00;
   localparam logic [7:0] TMR_DIV1_LAST = 8'h00;
   localparam logic [7:0] TMR_DIV8_LAST = 8'h07;
   localparam logic [7:0] TMR_DIV64_LAST = 8'h3F;
   localparam logic [7:0] TMR_DIV256_LAST = 8'hFF;
   typedef enum logic [2:0] {
      TMR_MODE_STOP,
      TMR_MODE_TIMER,
      TMR_MODE_GATED,
      TMR_MODE_SYNC_CNT,
      TMR_MODE_ASYNC_CNT
   } tmr_mode_t;
endpackage

/* File: logic/tmr_tick_if.sv */
// Interface carrying raw count ticks to the prescaler and divided ticks back.
interface tmr_tick_if;
   logic tick_in;
   logic clear;
   logic [1:0] div_sel;
   logic tick_out;
   modport ctrl (output tick_in, output clear, output div_sel,
      input tick_out);
   modport pre (input tick_in, input clear, input div_sel,
      output tick_out);
endinterface

/* File: logic/tmr_prescale.sv */
// Prescaler dividing the selected count source by 1, 8, 64 or 256.
module tmr_prescale (
   input wire logic sys_clk,
   input wire logic resetn,
   tmr_tick_if.pre tk
);
   import tmr_pkg::*;

   logic [7:0] pre_cnt_ff;
   logic [7:0] last_cnt;

   function automatic logic [7:0] div_last(input logic [1:0] sel);
      case (sel)
         2'h0: div_last = TMR_DIV1_LAST;
         2'h1: div_last = TMR_DIV8_LAST;
         2'h2: div_last = TMR_DIV64_LAST;
         default: div_last = TMR_DIV256_LAST;
      endcase
   endfunction

   assign last_cnt = div_last(tk.div_sel);
   assign tk.tick_out = tk.tick_in & ~tk.clear
      & (pre_cnt_ff == last_cnt);

   // A clear also restarts the division so a new ratio starts cleanly.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pre_cnt_ff <= TMR_PRE_RST;
      end else if (tk.clear || tk.tick_out) begin
         pre_cnt_ff <= TMR_PRE_RST;
      end else if (tk.tick_in) begin
         pre_cnt_ff <= 8'(pre_cnt_ff + 8'h01);
      end
   end

   a_pre_advance: assert property (@(posedge sys_clk) disable iff (!resetn)
      tk.tick_in && !tk.tick_out && !tk.clear |=>
      pre_cnt_ff == 8'($past(pre_cnt_ff) + 8'h01))
      else $error("Prescaler did not advance on a tick.");
   a_pre_ratio: assert property (@(posedge sys_clk) disable iff (!resetn)
      tk.tick_out |-> tk.tick_in && pre_cnt_ff == div_last(tk.div_sel))
      else $error("Prescaler output at the wrong count.");
endmodule

/* File: logic/tmr_timer.sv */
// Sixteen-bit interval timer and counter with an Avalon-MM register port.

module tmr_timer (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [tmr_pkg::TMR_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [tmr_pkg::TMR_DW-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [tmr_pkg::TMR_DW-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic external_count_input,
   input wire logic gate_input,
   input wire logic cpu_idle,
   input wire logic cpu_sleep,
   output logic irq_flag,
   output logic irq_request,
   output logic [2:0] irq_priority
);
   import tmr_pkg::*;

   tmr_tick_if tk ();

   logic ack_ff;
   logic [TMR_DW-1:0] rdata_ff;
   logic [15:0] ctrl_ff;
   logic [15:0] period_ff;
   logic [15:0] count_ff;
   logic flag_ff;
   logic [3:0] irqcfg_ff;
   logic ext_meta_ff, ext_sync_ff, ext_prev_ff, ext_align_ff, ext_alprev_ff;
   logic gate_meta_ff, gate_sync_ff, gate_prev_ff;
   logic wr_en, ctrl_wr, period_wr, count_wr, status_wr, irqcfg_wr;
   logic [15:0] wdata16;
   tmr_mode_t mode;
   logic raw_tick, halt, match, gate_fall, flag_clr;

   function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [15:0] nw, input logic [1:0] be);
      merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
   endfunction

   // Bus slave: every access is answered one cycle after it appears.
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
   assign avs_readdata = rdata_ff;
   assign wr_en = avs_write & ack_ff;
   assign wdata16 = avs_writedata[15:0];
   assign ctrl_wr = wr_en && avs_address == TMR_CTRL_OFS;
   assign period_wr = wr_en && avs_address == TMR_PERIOD_OFS;
   assign count_wr = wr_en && avs_address == TMR_COUNT_OFS;
   assign status_wr = wr_en && avs_address == TMR_STATUS_OFS;
   assign irqcfg_wr = wr_en && avs_address == TMR_IRQCFG_OFS;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (avs_read | avs_write) & ~ack_ff;
      end
   end

   // Read data is captured in the waiting cycle so it stands at acceptance.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_ff <= '0;
      end else if (avs_read && !ack_ff) begin
         case (avs_address)
            TMR_CTRL_OFS: rdata_ff <= {16'h0000,
               ctrl_ff & TMR_CTRL_MASK};
            TMR_PERIOD_OFS: rdata_ff <= {16'h0000, period_ff};
            TMR_COUNT_OFS: rdata_ff <= {16'h0000, count_ff};
            TMR_STATUS_OFS: rdata_ff <= {31'h0, flag_ff};
            TMR_IRQCFG_OFS: rdata_ff <= {28'h0000000, irqcfg_ff};
            default: rdata_ff <= '0;
         endcase
      end
   end

   // Unimplemented control bits are never stored, so they cannot read as one.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_ff <= TMR_CTRL_RST;
      end else if (ctrl_wr) begin
         ctrl_ff <= merge16(ctrl_ff, wdata16, avs_byteenable[1:0])
            & TMR_CTRL_MASK;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         period_ff <= TMR_PERIOD_RST;
      end else if (period_wr) begin
         period_ff <= merge16(period_ff, wdata16, avs_byteenable[1:0]);
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         irqcfg_ff <= TMR_IRQCFG_RST;
      end else if (irqcfg_wr && avs_byteenable[0]) begin
         irqcfg_ff <= avs_writedata[3:0];
      end
   end

   assign irq_priority = irqcfg_ff[TMR_IRQ_PRIO_LSB +: 3];

   // Pin synchronisers; the second stage and the delayed copies behind it feed the edge detectors.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ext_meta_ff <= 1'b0;
         ext_sync_ff <= 1'b0;
         ext_prev_ff <= 1'b0;
         ext_align_ff <= 1'b0;
         ext_alprev_ff <= 1'b0;
      end else begin
         ext_meta_ff <= external_count_input;
         ext_sync_ff <= ext_meta_ff;
         ext_prev_ff <= ext_sync_ff;
         ext_align_ff <= ext_sync_ff;
         ext_alprev_ff <= ext_align_ff;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         gate_meta_ff <= 1'b0;
         gate_sync_ff <= 1'b0;
         gate_prev_ff <= 1'b0;
      end else begin
         gate_meta_ff <= gate_input;
         gate_sync_ff <= gate_meta_ff;
         gate_prev_ff <= gate_sync_ff;
      end
   end

   always_comb begin
      if (!ctrl_ff[TMR_ON_BIT]) begin
         mode = TMR_MODE_STOP;
      end else if (ctrl_ff[TMR_CLKSRC_BIT]) begin
         mode = ctrl_ff[TMR_RESYNC_BIT] ? TMR_MODE_SYNC_CNT
            : TMR_MODE_ASYNC_CNT;
      end else begin
         mode = ctrl_ff[TMR_GATED_BIT] ? TMR_MODE_GATED
            : TMR_MODE_TIMER;
      end
   end

   // The instruction clock stops in sleep; only the unsynchronised external
   // path keeps counting there, at the price of one less alignment stage.
   always_comb begin
      case (mode)
         TMR_MODE_TIMER: raw_tick = ~cpu_sleep;
         TMR_MODE_GATED: raw_tick = ~cpu_sleep & gate_sync_ff;
         TMR_MODE_SYNC_CNT: raw_tick = ~cpu_sleep & ext_align_ff
            & ~ext_alprev_ff;
         TMR_MODE_ASYNC_CNT: raw_tick = ext_sync_ff & ~ext_prev_ff;
         default: raw_tick = 1'b0;
      endcase
   end

   assign halt = ctrl_ff[TMR_IDLE_HALT_BIT] & cpu_idle;
   assign tk.tick_in = raw_tick & ~halt;
   assign tk.clear = (mode == TMR_MODE_STOP) | ctrl_wr;
   assign tk.div_sel = ctrl_ff[TMR_PRESCALE_LSB +: 2];

   tmr_prescale u_prescale (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .tk(tk.pre)
   );

   assign match = tk.tick_out && count_ff == period_ff;
   assign gate_fall = mode == TMR_MODE_GATED && gate_prev_ff
      && !gate_sync_ff;

   // A software write of the count overrides a coincident tick.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         count_ff <= TMR_COUNT_RST;
      end else if (count_wr) begin
         count_ff <= merge16(count_ff, wdata16, avs_byteenable[1:0]);
      end else if (match) begin
         count_ff <= TMR_COUNT_RST;
      end else if (tk.tick_out) begin
         count_ff <= 16'(count_ff + 16'h0001);
      end
   end

   // Status flag is write-one-to-clear; a new event wins over the clear.
   assign flag_clr = status_wr && avs_byteenable[0]
      && avs_writedata[TMR_FLAG_BIT];

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= match | gate_fall | (flag_ff & ~flag_clr);
      end
   end

   assign irq_flag = flag_ff;
   assign irq_request = flag_ff & irqcfg_ff[TMR_IRQ_EN_BIT];

   a_bus_answer: assert property (@(posedge sys_clk) disable iff (!resetn)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("Bus access not answered in one cycle.");
   a_match_wrap: assert property (@(posedge sys_clk) disable iff (!resetn)
      match && !count_wr |=> count_ff == 16'h0000 && flag_ff)
      else $error("Period match did not wrap and flag.");
   a_count_step: assert property (@(posedge sys_clk) disable iff (!resetn)
      tk.tick_out && !match && !count_wr |=>
      count_ff == 16'($past(count_ff) + 16'h0001))
      else $error("Counter did not step on a divided tick.");
   a_gate_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
      gate_fall |=> flag_ff)
      else $error("Gate falling edge did not set the flag.");
   a_stop_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      !ctrl_ff[TMR_ON_BIT] && !count_wr |=> $stable(count_ff))
      else $error("Stopped timer changed its count.");
   a_idle_halt: assert property (@(posedge sys_clk) disable iff (!resetn)
      ctrl_ff[TMR_IDLE_HALT_BIT] && cpu_idle |-> !tk.tick_in)
      else $error("Timer counted in idle with halt set.");
   a_gate_only: assert property (@(posedge sys_clk) disable iff (!resetn)
      ctrl_ff[TMR_GATED_BIT] && !ctrl_ff[TMR_CLKSRC_BIT] && !gate_sync_ff
      |-> !tk.tick_in)
      else $error("Gated timer counted with gate low.");
   a_async_sleep: assert property (@(posedge sys_clk) disable iff (!resetn)
      mode == TMR_MODE_ASYNC_CNT && cpu_sleep && !halt
      && ext_sync_ff && !ext_prev_ff |-> tk.tick_in)
      else $error("Async counter missed an edge in sleep.");
   a_sync_sleep: assert property (@(posedge sys_clk) disable iff (!resetn)
      mode == TMR_MODE_SYNC_CNT && cpu_sleep |-> !tk.tick_in)
      else $error("Synchronous counter ticked in sleep.");
   a_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
      avs_read && !ack_ff && avs_address == TMR_CTRL_OFS |=>
      (avs_readdata[15:0] & ~TMR_CTRL_MASK) == 16'h0000)
      else $error("Unimplemented control bit read as one.");

   c_match_wrap: cover property (@(posedge sys_clk) disable iff (!resetn)
      match ##1 irq_request);
   c_gate_fall: cover property (@(posedge sys_clk) disable iff (!resetn)
      gate_fall);
   c_async_sleep: cover property (@(posedge sys_clk) disable iff (!resetn)
      mode == TMR_MODE_ASYNC_CNT && cpu_sleep && tk.tick_out);
endmodule

/* File: sim/tmr_pin_model.sv */
// Model of the external count pin and the gate pin that feed the timer.
module tmr_pin_model (
   input wire logic sys_clk,
   output logic external_count_input,
   output logic gate_input
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      external_count_input = 1'b0;
      gate_input = 1'b0;
   end
   // Pulses last three cycles so that both synchroniser stages see them.
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         external_count_input <= 1'b1;
         repeat (3) @(posedge sys_clk);
         external_count_input <= 1'b0;
         repeat (3) @(posedge sys_clk);
      end
   endtask
   task automatic set_gate(input logic v);
      @(posedge sys_clk);
      gate_input <= v;
   endtask
endmodule

/* File: sim/tb_top.sv */
// Self-checking testbench of the interval timer over its register port.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tmr_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn;
   logic [TMR_AW-1:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [TMR_DW-1:0] avs_writedata;
   logic [TMR_DW-1:0] avs_readdata;
   logic avs_waitrequest;
   logic external_count_input;
   logic gate_input;
   logic cpu_idle;
   logic cpu_sleep;
   logic irq_flag;
   logic irq_request;
   logic [2:0] irq_priority;
   logic wait_seen;
   logic [31:0] rd_seen;
   logic [31:0] rv;
   int err_total = 0;
   int samples_checked = 0;
   int cyc_count = 0;
   int n;
   int divs [4] = '{1, 8, 64, 256};
   logic [15:0] ext_ctl [5] = '{16'h8002, 16'h8006, 16'h8042, 16'h8002,
      16'h8006};
   logic ext_slp [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
   logic [31:0] ext_exp [5] = '{32'h5, 32'h5, 32'h5, 32'h5, 32'h0};
   tmr_timer dut (
      .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .external_count_input(external_count_input),
      .gate_input(gate_input), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
      .irq_flag(irq_flag), .irq_request(irq_request),
      .irq_priority(irq_priority));
   tmr_pin_model pins (
      .sys_clk(sys_clk), .external_count_input(external_count_input),
      .gate_input(gate_input));
   always #12.5 sys_clk = ~sys_clk;
   // Values standing just before each rising edge, free of edge races.
   always @(negedge sys_clk) begin
      wait_seen <= avs_waitrequest;
      rd_seen <= avs_readdata;
   end
   always @(posedge sys_clk) begin
      cyc_count <= cyc_count + 1;
      if (cyc_count == 30000) begin
         err_total++;
         end_of_test();
      end
   end
   task automatic end_of_test;
      if (err_total == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // The request is held until waitrequest is seen low at a rising edge.
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      do @(posedge sys_clk); while (wait_seen !== 1'b0);
      rv = rd_seen;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rv, exp);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   initial begin
      resetn = 1'b0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      cpu_idle = 1'b0;
      cpu_sleep = 1'b0;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      rd(TMR_CTRL_OFS, 32'h0);
      rd(TMR_PERIOD_OFS, 32'h0000FFFF);
      rd(TMR_COUNT_OFS, 32'h0);
      wr(TMR_CTRL_OFS, 32'h0000FFFF);
      rd(TMR_CTRL_OFS, 32'h0000A076);
      wr(TMR_CTRL_OFS, 32'h0);
      rd(8'h20, 32'h0);
      wr(TMR_COUNT_OFS, 32'h5);
      cyc(20);
      rd(TMR_COUNT_OFS, 32'h5);
      for (int c = 0; c < 4; c++) begin
         wr(TMR_CTRL_OFS, 32'h0);
         wr(TMR_COUNT_OFS, 32'h0);
         wr(TMR_STATUS_OFS, 32'h1);
         wr(TMR_PERIOD_OFS, 32'h3);
         wr(TMR_CTRL_OFS, 32'h8000 | (c << 4));
         n = 0;
         while (irq_flag !== 1'b1 && n < 1200) begin
            @(negedge sys_clk);
            n++;
         end
         rv = 32'(n >= 4 * divs[c] - 3 && n <= 4 * divs[c] + 4);
         chk(rv, 32'h1);
      end
      wr(TMR_CTRL_OFS, 32'h0);
      wr(TMR_IRQCFG_OFS, 32'hF);
      cyc(1);
      chk({29'h0, irq_priority, irq_request}, 32'hF);
      wr(TMR_STATUS_OFS, 32'h1);
      cyc(1);
      chk({30'h0, irq_flag, irq_request}, 32'h0);
      wr(TMR_COUNT_OFS, 32'h0);
      cpu_idle <= 1'b1;
      wr(TMR_CTRL_OFS, 32'hA000);
      cyc(20);
      rd(TMR_COUNT_OFS, 32'h0);
      wr(TMR_CTRL_OFS, 32'h8000);
      cyc(20);
      wr(TMR_CTRL_OFS, 32'h0);
      cpu_idle <= 1'b0;
      bus(1'b0, TMR_COUNT_OFS, 32'h0);
      chk(32'(rv != 32'h0), 32'h1);
      wr(TMR_PERIOD_OFS, 32'h0000FFFF);
      wr(TMR_STATUS_OFS, 32'h1);
      wr(TMR_COUNT_OFS, 32'h0);
      wr(TMR_CTRL_OFS, 32'h8040);
      cyc(20);
      rd(TMR_COUNT_OFS, 32'h0);
      pins.set_gate(1'b1);
      cyc(20);
      chk({31'h0, irq_flag}, 32'h0);
      pins.set_gate(1'b0);
      cyc(6);
      chk({31'h0, irq_flag}, 32'h1);
      wr(TMR_CTRL_OFS, 32'h0);
      bus(1'b0, TMR_COUNT_OFS, 32'h0);
      chk(32'(rv >= 32'h0F && rv <= 32'h19), 32'h1);
      // Gate stays low here, so the third entry proves gating is ignored.
      for (int e = 0; e < 5; e++) begin
         wr(TMR_COUNT_OFS, 32'h0);
         wr(TMR_CTRL_OFS, {16'h0, ext_ctl[e]});
         cpu_sleep <= ext_slp[e];
         pins.pulse(5);
         cyc(8);
         wr(TMR_CTRL_OFS, 32'h0);
         cpu_sleep <= 1'b0;
         rd(TMR_COUNT_OFS, ext_exp[e]);
      end
      end_of_test();
   end
endmodule
